// >>> logic/static_mem_wait_pkg.sv
// constants and carrier types for the static memory wait-extension block
package static_mem_wait_pkg;

  // =====================================================================
  // wait-state field and extension queue
  localparam int unsigned WS_W            = 3;
  localparam logic [2:0]  WS_ZERO         = 3'h0;
  localparam logic [2:0]  WS_FOUR         = 3'h4;
  localparam logic [4:0]  COUNTDOWN_TWO   = 5'h02;
  localparam int unsigned EXT_W           = 6;
  localparam logic [5:0]  EXT_MAX         = 6'h3F;

  // =====================================================================
  // strobe release after wait deassertion, bus clocks (max allowed)
  localparam int unsigned CS_RELEASE_MAX  = 4;
  localparam int unsigned OE_RELEASE_MAX  = 4;
  localparam int unsigned WE_RELEASE_MAX  = 3;

  // =====================================================================
  // reset values
  localparam logic [4:0]  COUNT_RST       = 5'h00;
  localparam logic [5:0]  EXT_RST         = 6'h00;

  typedef enum logic [3:0]
  {
    ST_IDLE  = 4'h1,
    ST_COUNT = 4'h2,
    ST_WAIT  = 4'h4,
    ST_DRAIN = 4'h8
  } state_t;

  // request from the bus side
  typedef struct packed
  {
    logic            valid;
    logic            write;
    logic [WS_W-1:0] wait_state_count;
  } access_req_t;

  // memory strobes, active low
  typedef struct packed
  {
    logic bank_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
  } mem_strobe_t;

  typedef struct packed
  {
    state_t           state;
    logic [4:0]       count;
    logic [EXT_W-1:0] ext;
    logic             write;
    logic             wait_meta;
    logic             wait_sync;
    logic             done;
    mem_strobe_t      strobe;
  } ctrl_state_t;

endpackage

// >>> logic/static_mem_wait_extension.sv
// static memory access sequencer with wait states and external wait input
`timescale 1ns/10ps

module static_mem_wait_extension
  import static_mem_wait_pkg::*;
(
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              resetn,
  // access request
  input  wire static_mem_wait_pkg::access_req_t  req,
  output logic                                   req_ready,
  output logic                                   access_done,
  // arbitration toward dynamic memory
  output logic                                   static_busy,
  // memory pins
  input  wire logic                              ext_wait_n,
  output static_mem_wait_pkg::mem_strobe_t       strobe
);

  import static_mem_wait_pkg::*;

  ctrl_state_t s_q;
  ctrl_state_t s_d;

  // =====================================================================
  // timing notes
  // one access at a time; a request is taken only in idle
  // wait-low samples are queued from two cycles left onward
  // a wait line held low stalls the access with no upper bound,
  // so dynamic refresh stays blocked behind static_busy meanwhile
  // the synchroniser costs two clocks after the pin edge, which is
  // why a release in the wait state finishes with no drain cycle
  // queue saturates instead of wrapping on a stuck wait line

  // =====================================================================
  // decode helpers

  // strobes driven while an access is in flight
  function automatic mem_strobe_t start_strobes(input logic is_write);
    mem_strobe_t s;
    s.bank_select_n  = 1'b0;
    s.read_strobe_n  = is_write;
    s.write_strobe_n = ~is_write;
    return s;
  endfunction

  // all strobes released
  function automatic mem_strobe_t idle_strobes();
    mem_strobe_t s;
    s.bank_select_n  = 1'b1;
    s.read_strobe_n  = 1'b1;
    s.write_strobe_n = 1'b1;
    return s;
  endfunction

  // synchronised wait line is active low
  function automatic logic wait_asserted(input logic sync);
    return ~sync;
  endfunction

  // samples before two cycles remain change nothing
  function automatic logic in_queue_window(input logic [4:0] count);
    return (count <= COUNTDOWN_TWO);
  endfunction

  // push one extension cycle, held at the top
  function automatic logic [EXT_W-1:0] queue_push(input logic [EXT_W-1:0] ext);
    logic [EXT_W-1:0] n;
    n = ext;
    if (ext != EXT_MAX)
    begin
      n = ext + 6'h01;
    end
    return n;
  endfunction

  // pop one extension cycle, held at empty
  function automatic logic [EXT_W-1:0] queue_pop(input logic [EXT_W-1:0] ext);
    logic [EXT_W-1:0] n;
    n = ext;
    if (ext != EXT_RST)
    begin
      n = ext - 6'h01;
    end
    return n;
  endfunction

  // idle decode, shared by ready and busy
  function automatic logic in_idle(input state_t st);
    return (st == ST_IDLE);
  endfunction

  // =====================================================================
  // next state
  always_comb
  begin
    s_d      = s_q;
    s_d.done = 1'b0;
    s_d.wait_meta = ext_wait_n;
    s_d.wait_sync = s_q.wait_meta;
    case (s_q.state)
      ST_IDLE:
      begin
        if (req.valid)
        begin
          s_d.count                = {2'b00, req.wait_state_count};
          s_d.ext                  = EXT_RST;
          s_d.write                = req.write;
          s_d.strobe               = start_strobes(req.write);
          s_d.state                = ST_COUNT;
        end
      end
      ST_COUNT:
      begin
        if (wait_asserted(s_q.wait_sync) && in_queue_window(s_q.count))
        begin
          s_d.ext = queue_push(s_q.ext);
        end
        if (s_q.count != COUNT_RST)
        begin
          s_d.count = s_q.count - 5'h01;
        end
        else if (wait_asserted(s_q.wait_sync))
        begin
          s_d.state = ST_WAIT;
        end
        else
        begin
          s_d.state = ST_DRAIN;
        end
      end
      ST_WAIT:
      begin
        s_d.ext = queue_pop(s_q.ext);
        if (!wait_asserted(s_q.wait_sync))
        begin
          // no drain cycle: write strobe within three clocks
          s_d.ext    = EXT_RST;
          s_d.strobe = idle_strobes();
          s_d.done   = 1'b1;
          s_d.state  = ST_IDLE;
        end
      end
      ST_DRAIN:
      begin
        if (s_q.ext != EXT_RST)
        begin
          s_d.ext = queue_pop(s_q.ext);
        end
        else
        begin
          s_d.strobe = idle_strobes();
          s_d.done   = 1'b1;
          s_d.state  = ST_IDLE;
        end
      end
      default:
      begin
        s_d.state  = ST_IDLE;
        s_d.strobe = idle_strobes();
      end
    endcase
  end

  // =====================================================================
  // state register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q.state     <= ST_IDLE;
      s_q.count     <= COUNT_RST;
      s_q.ext       <= EXT_RST;
      s_q.write     <= 1'b0;
      s_q.wait_meta <= 1'b1;
      s_q.wait_sync <= 1'b1;
      s_q.done      <= 1'b0;
      s_q.strobe    <= '1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // =====================================================================
  // outputs
  // ready is combinational so a request may ride the same cycle as done
  assign req_ready   = in_idle(s_q.state);
  // one-cycle pulse, same edge as the strobe release
  assign access_done = s_q.done;
  // blocks dynamic accesses
  // dynamic side must hold off while this is high
  assign static_busy = ~in_idle(s_q.state);
  assign strobe      = s_q.strobe;

endmodule

// >>> tb/static_mem_wait_monitor.sv
// timing checker for the static memory wait-extension block
`timescale 1ns/10ps
module static_mem_wait_monitor
  import static_mem_wait_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // observed ports
  input wire static_mem_wait_pkg::access_req_t req,
  input wire logic req_ready,
  input wire logic access_done,
  input wire logic static_busy,
  input wire logic ext_wait_n,
  input wire static_mem_wait_pkg::mem_strobe_t strobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_hold; !ext_wait_n [*5] |-> !access_done; endproperty
  a_hold: assert property (p_hold) else $error("done under wait");
  property p_zero; req.valid && req_ready && req.wait_state_count == WS_ZERO |-> ##3 access_done;
  endproperty
  a_zero: assert property (p_zero) else $error("zero wait length");
  property p_four; req.valid && req_ready && req.wait_state_count == WS_FOUR |-> ##7 access_done;
  endproperty
  a_four: assert property (p_four) else $error("four wait length");
  property p_done; access_done |-> strobe == 3'h7; endproperty
  a_done: assert property (p_done) else $error("strobes not released");
  property p_cs; $rose(ext_wait_n) |-> ##[0:4] strobe.bank_select_n; endproperty
  a_cs: assert property (p_cs) else $error("select late");
  property p_oe; $rose(ext_wait_n) |-> ##[0:4] strobe.read_strobe_n; endproperty
  a_oe: assert property (p_oe) else $error("read strobe late");
  // write release counted from the pin edge
  property p_we; $rose(ext_wait_n) |-> ##[0:3] strobe.write_strobe_n; endproperty
  a_we: assert property (p_we) else $error("write strobe late");
  property p_busy; !strobe.bank_select_n |-> static_busy; endproperty
  a_busy: assert property (p_busy) else $error("busy low in access");
endmodule
bind static_mem_wait_extension static_mem_wait_monitor i_mon (.*);

// >>> tb/wait_peripheral.sv
// slow peripheral that stretches each access with its wait line
`timescale 1ns/10ps
module wait_peripheral
(
  // bench side
  input  wire logic       clk,
  input  wire logic [4:0] lag,
  input  wire logic [4:0] hold,
  // memory side
  input  wire logic       bank_select_n,
  output logic            ext_wait_n
);
  initial ext_wait_n = 1'b1;
  always @(negedge bank_select_n)
  begin
    if (hold != 0)
    begin
      repeat (lag) @(posedge clk);
      #2 ext_wait_n = 1'b0;
      repeat (hold) @(posedge clk);
      #2 ext_wait_n = 1'b1;
    end
  end
endmodule

// >>> tb/tb.sv
// self-checking bench for the static memory wait-extension block
`timescale 1ns/10ps
module tb;
  import static_mem_wait_pkg::*;
  logic        clk, resetn, req_ready, access_done, static_busy, ext_wait_n;
  access_req_t req;
  mem_strobe_t strobe;
  logic [4:0]  lag, hold;
  int          n_mismatch, n_compared, t, lo, hi;
  // write, count, lag, hold; wait rows keep count >= 2 + lag
  int rows [7][4] = '{'{0,0,0,0}, '{1,4,0,0}, '{0,7,0,0}, '{1,2,0,2}, '{0,2,0,3},
                      '{0,5,3,2}, '{1,3,1,6}};
  static_mem_wait_extension i_dut (.clk(clk), .resetn(resetn), .req(req), .req_ready(req_ready),
    .access_done(access_done), .static_busy(static_busy), .ext_wait_n(ext_wait_n), .strobe(strobe));
  wait_peripheral i_peer (.clk(clk), .lag(lag), .hold(hold), .bank_select_n(strobe.bank_select_n),
    .ext_wait_n(ext_wait_n));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    #200us;
    n_mismatch++;
    results();
  end
  initial
  begin
    resetn = 1'b0;
    req = '0;
    lag = '0;
    hold = '0;
    repeat (12) @(posedge clk);
    #2 resetn = 1'b1;
    chk("ready after reset", 8'h01, {7'h00, req_ready});
    // next request rides the same cycle as done
    foreach (rows[i])
    begin
      lag = 5'(rows[i][2]);
      hold = 5'(rows[i][3]);
      req = '{1'b1, rows[i][0][0], rows[i][1][2:0]};
      @(posedge clk);
      #2 req.valid = 1'b0;
      chk("strobe", {5'h00, 1'b0, rows[i][0][0], !rows[i][0][0]}, {5'h00, strobe});
      chk("busy", 8'h01, {7'h00, static_busy});
      chk("ready", 8'h00, {7'h00, req_ready});
      t = 0;
      while (access_done !== 1'b1 && t < 60)
      begin
        @(posedge clk);
        #2 t++;
      end
      lo = (hold != 0) ? rows[i][2] + hold + 1 : rows[i][1] + 2;
      hi = (hold != 0) ? rows[i][2] + hold + 4 : lo;
      chk("length ok", 8'h01, {7'h00, t >= lo && t <= hi});
      $display("test %0d done", i);
    end
    req = '{1'b1, 1'b0, 3'h7};
    @(posedge clk);
    #2 req.valid = 1'b0;
    repeat (3) @(posedge clk);
    #2 resetn = 1'b0;
    #1 chk("reset strobe", 8'h07, {5'h00, strobe});
    chk("reset busy", 8'h00, {7'h00, static_busy});
    chk("reset ready", 8'h01, {7'h00, req_ready});
    $display("test reset done");
    results();
  end
endmodule
